// file: rtl/rwic_pkg.sv
// constants and types for the reset, watchdog and interrupt control block
`default_nettype none
package rwic_pkg;
  localparam logic [15:0] RST_VEC       = 16'hfffe;
  localparam logic [15:0] SWI_VEC       = 16'hfffc;
  localparam logic [15:0] IRQ_VEC_LOW   = 16'hffec;
  localparam logic [15:0] SP_INIT       = 16'h00ff;
  localparam logic [7:0]  CCR_I_MASK    = 8'h08;
  localparam int          CCR_I_BIT     = 3;
  localparam logic [7:0]  CCR_RST       = 8'h08;
  localparam int          NSRC          = 8;
  localparam int          PIN_DRIVE_CYC = 34;
  localparam int          PIN_WAIT_CYC  = 38;
  localparam int          WD_SHORT_CYC  = 262144;
  localparam int          WD_LONG_CYC   = 1048576;
  localparam logic [2:0]  STACK_LAST    = 3'h4;
  localparam logic [2:0]  VEC_LAST      = 3'h1;
  localparam logic [2:0]  FILL_LAST     = 3'h2;
  localparam logic [7:0]  CAUSE_POR     = 8'h80;
  localparam logic [7:0]  CAUSE_PIN     = 8'h40;
  localparam logic [7:0]  CAUSE_WDOG    = 8'h20;
  localparam logic [7:0]  CAUSE_ILOP    = 8'h10;
  localparam logic [7:0]  CAUSE_ILAD    = 8'h08;
  localparam logic [7:0]  CAUSE_LVD     = 8'h02;
  localparam logic [7:0]  CAUSE_RST     = 8'h00;
  localparam logic        OPT_WD_EN_RST = 1'b1;
  localparam logic        OPT_LONG_RST  = 1'b1;

  typedef struct packed {
    logic wdEnable;
    logic wdLongSel;
  } rwic_opt_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  x;
    logic [7:0]  a;
    logic [7:0]  condition_code_reg;
  } rwic_regs_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PUSH = 3'h1,
    ST_VECT = 3'h3,
    ST_FILL = 3'h2,
    ST_POP  = 3'h6
  } rwic_state_t;
endpackage
`default_nettype wire

// file: rtl/rwic_reset_pin.sv
// reset pin drive and sample sequencer
`default_nettype none
module rwic_reset_pin (
  input  wire logic clk,
  input  wire logic rstB,
  input  wire logic enter,
  input  wire logic pinIn,
  output logic      pinOe,
  output var  logic holding,
  output var  logic sampleStb,
  output var  logic pinHeldLow
);
  localparam logic [6:0] DRIVE = 7'(rwic_pkg::PIN_DRIVE_CYC);
  localparam logic [6:0] LAST  = 7'(rwic_pkg::PIN_DRIVE_CYC + rwic_pkg::PIN_WAIT_CYC);
  logic [6:0] cnt;

  // sequence runs from entry until the pin has been sampled
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      holding <= 1'b1;
      cnt     <= 7'h0;
    end else if (enter) begin
      holding <= 1'b1;
      cnt     <= 7'h0;
    end else if (holding) begin
      holding <= cnt != LAST;
      cnt     <= cnt + 7'h1;
    end
  end

  assign pinOe = holding && cnt < DRIVE;

  // sample the released pin once
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      sampleStb  <= 1'b0;
      pinHeldLow <= 1'b0;
    end else begin
      sampleStb  <= holding && cnt == LAST;
      pinHeldLow <= holding && cnt == LAST && !pinIn;
    end
  end

  AST_PIN_DRIVE: assert property (@(posedge clk) disable iff (!rstB)
    enter |=> pinOe [*8])
    else $error("reset pin not driven after entry");
  AST_PIN_SAMPLE: assert property (@(posedge clk) disable iff (!rstB)
    holding && cnt == LAST |=> sampleStb && !holding && pinHeldLow == !$past(pinIn))
    else $error("reset pin sample wrong");
endmodule
`default_nettype wire

// file: rtl/rwic_top.sv
// reset, watchdog and interrupt entry/return control
`default_nettype none
module rwic_top #(
  parameter int WD_SHORT_CYC = rwic_pkg::WD_SHORT_CYC,
  parameter int WD_LONG_CYC  = rwic_pkg::WD_LONG_CYC
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic                       lvdReset,
  input  wire logic                       illegalOpReset,
  input  wire logic                       illegalAddrReset,
  input  wire logic                       debugReset,
  input  wire logic                       resetPinIn,
  output logic                            resetPinOut,
  output logic                            resetPinOe,
  output logic                            sysReset,
  output var  logic [7:0]                 resetCause,
  input  wire logic                       causeWrite,
  input  wire logic                       optWrite,
  input  wire rwic_pkg::rwic_opt_t        optWdata,
  output var  rwic_pkg::rwic_opt_t        optState,
  output var  logic                       optLocked,
  input  wire logic                       backgroundActive,
  input  wire logic [rwic_pkg::NSRC-1:0]  irqEvent,
  input  wire logic [rwic_pkg::NSRC-1:0]  irqClear,
  input  wire logic [rwic_pkg::NSRC-1:0]  irqEnable,
  output var  logic [rwic_pkg::NSRC-1:0]  irqFlag,
  input  wire logic                       instrBoundary,
  input  wire logic                       swiExec,
  input  wire logic                       rtiExec,
  input  wire rwic_pkg::rwic_regs_t       coreRegs,
  input  wire logic [15:0]                coreSp,
  output logic                            coreHold,
  output var  logic                       regLoad,
  output var  rwic_pkg::rwic_regs_t       loadRegs,
  output var  logic [15:0]                loadSp,
  output var  logic                       loadAx,
  output logic [15:0]                     memAddr,
  output logic [7:0]                      memWdata,
  output logic                            memWr,
  output logic                            memRd,
  input  wire logic [7:0]                 memRdata,
  output var  logic [7:0]                 fillByte,
  output var  logic                       fillValid
);
  logic                      rstMeta;
  logic                      rstSyncB;
  logic                      holding;
  logic                      sampleStb;
  logic                      pinHeldLow;
  logic                      wdTimeout;
  logic                      wdRun;
  logic                      pinExt;
  logic                      enterReset;
  logic [7:0]                causeHold;
  logic [rwic_pkg::NSRC-1:0] pending;
  logic                      irqTake;
  logic                      startEntry;
  rwic_pkg::rwic_state_t     state;
  logic [2:0]                step;
  logic                      ph;
  logic                      fromReset;
  logic                      isRti;
  logic [15:0]               sp;
  logic [15:0]               pcAcc;
  logic [15:0]               vecAddr;
  rwic_pkg::rwic_regs_t      frame;

  // index of the highest priority pending source, higher index wins
  function automatic logic [2:0] topSource(input logic [rwic_pkg::NSRC-1:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < rwic_pkg::NSRC; i++) begin
      if (p[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // vector address of a source
  function automatic logic [15:0] srcVector(input logic [rwic_pkg::NSRC-1:0] p);
    return rwic_pkg::IRQ_VEC_LOW + {12'h0, topSource(p), 1'b0};
  endfunction

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta  <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncB <= rstMeta;
    end
  end

  // reset pin: driven low only, released to the pullup
  assign resetPinOut = 1'b0;
  assign sysReset    = holding;

  rwic_reset_pin uPin (
    .clk        (core_clk),
    .rstB       (rstSyncB),
    .enter      (enterReset),
    .pinIn      (resetPinIn),
    .pinOe      (resetPinOe),
    .holding    (holding),
    .sampleStb  (sampleStb),
    .pinHeldLow (pinHeldLow)
  );

  // any source outside the sequence starts a new reset
  assign pinExt     = !resetPinIn && !holding;
  assign enterReset = !holding && (lvdReset || illegalOpReset || illegalAddrReset
                      || debugReset || wdTimeout || pinExt);

  // causes seen at entry; the debug request has no bit
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      causeHold <= rwic_pkg::CAUSE_POR;
    end else if (enterReset) begin
      causeHold <= (lvdReset ? rwic_pkg::CAUSE_LVD : 8'h00)
                 | (illegalOpReset ? rwic_pkg::CAUSE_ILOP : 8'h00)
                 | (illegalAddrReset ? rwic_pkg::CAUSE_ILAD : 8'h00)
                 | (wdTimeout ? rwic_pkg::CAUSE_WDOG : 8'h00)
                 | (pinExt ? rwic_pkg::CAUSE_PIN : 8'h00);
    end
  end

  // cause register updates when the pin sample completes
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      resetCause <= rwic_pkg::CAUSE_RST;
    end else if (sampleStb) begin
      resetCause <= causeHold | (pinHeldLow ? rwic_pkg::CAUSE_PIN : 8'h00);
    end
  end

  // write-once options, defaults restored by every reset
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      optState  <= '{wdEnable: rwic_pkg::OPT_WD_EN_RST, wdLongSel: rwic_pkg::OPT_LONG_RST};
      optLocked <= 1'b0;
    end else if (holding) begin
      optState  <= '{wdEnable: rwic_pkg::OPT_WD_EN_RST, wdLongSel: rwic_pkg::OPT_LONG_RST};
      optLocked <= 1'b0;
    end else if (optWrite && !optLocked) begin
      optState  <= optWdata;
      optLocked <= 1'b1;
    end
  end

  // watchdog runs only when enabled, out of reset and out of debug
  assign wdRun = optState.wdEnable && !backgroundActive && !holding;

  rwic_watchdog #(
    .SHORT_CYC (WD_SHORT_CYC),
    .LONG_CYC  (WD_LONG_CYC)
  ) uWdog (
    .clk     (core_clk),
    .rstB    (rstSyncB),
    .run     (wdRun),
    .service (causeWrite),
    .longSel (optState.wdLongSel),
    .timeout (wdTimeout)
  );

  // sticky interrupt flags; an event beats a clear in the same cycle
  for (genvar i = 0; i < rwic_pkg::NSRC; i++) begin : gFlag
    always_ff @(posedge core_clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
        irqFlag[i] <= 1'b0;
      end else if (holding) begin
        irqFlag[i] <= 1'b0;
      end else if (irqEvent[i]) begin
        irqFlag[i] <= 1'b1;
      end else if (irqClear[i]) begin
        irqFlag[i] <= 1'b0;
      end
    end
  end

  // qualification by local enable and global mask
  assign pending    = irqFlag & irqEnable;
  assign irqTake    = |pending && !coreRegs.condition_code_reg[rwic_pkg::CCR_I_BIT];
  assign startEntry = swiExec || (instrBoundary && irqTake);

  // sequencer state and byte step
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      state     <= rwic_pkg::ST_IDLE;
      step      <= 3'h0;
      ph        <= 1'b0;
      fromReset <= 1'b0;
      isRti     <= 1'b0;
    end else if (holding) begin
      state <= rwic_pkg::ST_IDLE;
      step  <= 3'h0;
      ph    <= 1'b0;
    end else begin
      case (state)
        rwic_pkg::ST_IDLE: begin
          step <= 3'h0;
          ph   <= 1'b0;
          if (sampleStb) begin
            state     <= rwic_pkg::ST_VECT;
            fromReset <= 1'b1;
            isRti     <= 1'b0;
          end else if (rtiExec) begin
            state     <= rwic_pkg::ST_POP;
            fromReset <= 1'b0;
            isRti     <= 1'b1;
          end else if (startEntry) begin
            state     <= rwic_pkg::ST_PUSH;
            fromReset <= 1'b0;
            isRti     <= 1'b0;
          end
        end
        rwic_pkg::ST_PUSH: begin
          if (step == rwic_pkg::STACK_LAST) begin
            state <= rwic_pkg::ST_VECT;
            step  <= 3'h0;
          end else begin
            step <= step + 3'h1;
          end
        end
        rwic_pkg::ST_VECT: begin
          ph <= !ph;
          if (ph && step == rwic_pkg::VEC_LAST) begin
            state <= rwic_pkg::ST_FILL;
            step  <= 3'h0;
          end else if (ph) begin
            step <= step + 3'h1;
          end
        end
        rwic_pkg::ST_FILL: begin
          ph <= !ph;
          if (ph && step == rwic_pkg::FILL_LAST) begin
            state <= rwic_pkg::ST_IDLE;
            step  <= 3'h0;
          end else if (ph) begin
            step <= step + 3'h1;
          end
        end
        rwic_pkg::ST_POP: begin
          ph <= !ph;
          if (ph && step == rwic_pkg::STACK_LAST) begin
            state <= rwic_pkg::ST_FILL;
            step  <= 3'h0;
          end else if (ph) begin
            step <= step + 3'h1;
          end
        end
        default: begin
          state <= rwic_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // stack pointer, captured frame, vector and fetch address
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      sp      <= rwic_pkg::SP_INIT;
      pcAcc   <= 16'h0;
      vecAddr <= rwic_pkg::RST_VEC;
      frame   <= '{pc: 16'h0, x: 8'h0, a: 8'h0, condition_code_reg: rwic_pkg::CCR_RST};
    end else if (state == rwic_pkg::ST_IDLE && !holding) begin
      if (sampleStb) begin
        sp        <= rwic_pkg::SP_INIT;
        vecAddr   <= rwic_pkg::RST_VEC;
        frame.condition_code_reg <= rwic_pkg::CCR_RST;
      end else if (rtiExec) begin
        sp <= coreSp;
      end else if (startEntry) begin
        sp      <= coreSp;
        frame   <= coreRegs;
        vecAddr <= swiExec ? rwic_pkg::SWI_VEC : srcVector(pending);
      end
    end else if (state == rwic_pkg::ST_PUSH) begin
      sp <= sp - 16'h1;
    end else if (state == rwic_pkg::ST_VECT && ph) begin
      if (step == 3'h0) begin
        pcAcc[15:8] <= memRdata;
      end else begin
        pcAcc[7:0] <= memRdata;
      end
    end else if (state == rwic_pkg::ST_POP && ph) begin
      sp <= sp + 16'h1;
      case (step)
        3'h0: frame.condition_code_reg <= memRdata;
        3'h1: frame.a <= memRdata;
        3'h2: frame.x <= memRdata;
        3'h3: frame.pc[15:8] <= memRdata;
        default: pcAcc <= {frame.pc[15:8], memRdata};
      endcase
    end
  end

  // bus requests; one write per cycle, reads take issue and capture
  always_comb begin
    memWr    = state == rwic_pkg::ST_PUSH;
    memRd    = !ph && (state == rwic_pkg::ST_VECT || state == rwic_pkg::ST_FILL
               || state == rwic_pkg::ST_POP);
    memAddr  = 16'h0;
    memWdata = 8'h0;
    case (state)
      rwic_pkg::ST_PUSH: memAddr = sp;
      rwic_pkg::ST_VECT: memAddr = vecAddr + {13'h0, step};
      rwic_pkg::ST_FILL: memAddr = pcAcc + {13'h0, step};
      rwic_pkg::ST_POP:  memAddr = sp + 16'h1;
      default:           memAddr = 16'h0;
    endcase
    if (state == rwic_pkg::ST_PUSH) begin
      case (step)
        3'h0:    memWdata = frame.pc[7:0];
        3'h1:    memWdata = frame.pc[15:8];
        3'h2:    memWdata = frame.x;
        3'h3:    memWdata = frame.a;
        default: memWdata = frame.condition_code_reg;
      endcase
    end
  end

  // prefetch bytes and final register hand-back to the core
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      fillValid <= 1'b0;
      fillByte  <= 8'h0;
      regLoad   <= 1'b0;
      loadRegs  <= '{pc: 16'h0, x: 8'h0, a: 8'h0, condition_code_reg: rwic_pkg::CCR_RST};
      loadSp    <= rwic_pkg::SP_INIT;
      loadAx    <= 1'b0;
    end else begin
      fillValid <= state == rwic_pkg::ST_FILL && ph;
      if (state == rwic_pkg::ST_FILL && ph) begin
        fillByte <= memRdata;
      end
      regLoad <= state == rwic_pkg::ST_FILL && ph && step == rwic_pkg::FILL_LAST;
      if (state == rwic_pkg::ST_FILL && ph && step == rwic_pkg::FILL_LAST) begin
        loadRegs.pc  <= pcAcc;
        loadRegs.x   <= frame.x;
        loadRegs.a   <= frame.a;
        loadRegs.condition_code_reg <= isRti ? frame.condition_code_reg : frame.condition_code_reg | rwic_pkg::CCR_I_MASK;
        loadSp       <= sp;
        loadAx       <= isRti;
      end
    end
  end

  // core stalls during reset and any sequence
  assign coreHold = holding || state != rwic_pkg::ST_IDLE;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSyncB);

  sequence pushFrame;
    memWdata == frame.pc[7:0] ##1 memWdata == frame.pc[15:8]
    ##1 memWdata == frame.x ##1 memWdata == frame.a ##1 memWdata == frame.condition_code_reg;
  endsequence

  AST_PUSH_ORDER: assert property (
    state == rwic_pkg::ST_PUSH && step == 3'h0 |-> pushFrame)
    else $error("stack frame order wrong");
  AST_SP_AFTER_PUSH: assert property (
    state == rwic_pkg::ST_PUSH && step == 3'h0 |-> ##5 sp == $past(sp, 5) - 16'h5)
    else $error("stack pointer not five below");
  AST_RST_VECTOR: assert property (
    state == rwic_pkg::ST_VECT && fromReset && !ph |-> memRd
    && memAddr[15:1] == rwic_pkg::RST_VEC[15:1])
    else $error("reset vector address wrong");
  AST_RST_LOAD: assert property (
    $fell(holding) && !enterReset |-> ##[1:16] regLoad && loadSp == rwic_pkg::SP_INIT
    && loadRegs.condition_code_reg[rwic_pkg::CCR_I_BIT])
    else $error("reset did not load stack pointer");
  AST_ENTRY_MASK: assert property (
    regLoad && !loadAx |-> loadRegs.condition_code_reg[rwic_pkg::CCR_I_BIT])
    else $error("entry left interrupts unmasked");
  AST_PIN_CAUSE: assert property (
    sampleStb && pinHeldLow |=> resetCause[6])
    else $error("pin cause not recorded");
  AST_SERVICE_KEEPS: assert property (
    causeWrite && !sampleStb |=> $stable(resetCause))
    else $error("service write altered cause");
  AST_OPT_ONCE: assert property (
    optLocked && !holding |=> $stable(optState) || holding)
    else $error("options changed after lock");
  AST_WD_TO_RESET: assert property (
    wdTimeout && !holding |=> holding && resetPinOe)
    else $error("watchdog expiry did not reset");
  AST_MASKED: assert property (
    state == rwic_pkg::ST_IDLE && !holding && coreRegs.condition_code_reg[rwic_pkg::CCR_I_BIT]
    && !swiExec && !rtiExec && !sampleStb |=> state == rwic_pkg::ST_IDLE)
    else $error("masked request was taken");
  AST_FILL_THREE: assert property (
    regLoad |-> fillValid && $past(fillValid, 2) && $past(fillValid, 4) && !$past(fillValid, 6))
    else $error("prefetch not three bytes");
endmodule
`default_nettype wire

// file: rtl/rwic_watchdog.sv
// watchdog counter with selectable timeout
`default_nettype none
module rwic_watchdog #(
  parameter int SHORT_CYC = rwic_pkg::WD_SHORT_CYC,
  parameter int LONG_CYC  = rwic_pkg::WD_LONG_CYC
) (
  input  wire logic clk,
  input  wire logic rstB,
  input  wire logic run,
  input  wire logic service,
  input  wire logic longSel,
  output var  logic timeout
);
  logic [20:0] count;
  logic [20:0] limit;

  // last count before expiry for the selected period
  assign limit = longSel ? 21'(LONG_CYC - 1) : 21'(SHORT_CYC - 1);

  // count while running, zero on service or when stopped
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      count <= 21'h0;
    end else if (!run || service || count == limit) begin
      count <= 21'h0;
    end else begin
      count <= count + 21'h1;
    end
  end

  // expiry pulse towards the reset logic
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      timeout <= 1'b0;
    end else begin
      timeout <= run && !service && count == limit;
    end
  end

  AST_WD_EXPIRE: assert property (@(posedge clk) disable iff (!rstB)
    run && !service && count == limit |=> timeout && count == 21'h0)
    else $error("watchdog missed its expiry");
  AST_WD_STOPPED: assert property (@(posedge clk) disable iff (!rstB)
    !run ##1 !run |-> count == 21'h0 && !timeout)
    else $error("watchdog counted while stopped");
endmodule
`default_nettype wire

// file: testbench/rwic_mem_model.sv
// memory model standing on the core side bus of the block
`default_nettype none
module rwic_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [7:0]  rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  // every byte starts as its low address byte plus a fixed offset
  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) + 8'h11;
  end
  // writes land at once; read data valid one cycle later, else it toggles
  always @(posedge clk) begin
    if (wr) mem[addr] <= wdata;
    rdata <= rd ? mem[addr] : ~rdata;
  end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the reset, watchdog and interrupt block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 core_clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 causeWrite = 1'b0, optWrite = 1'b0, boundary = 1'b0, return_from_interrupt_instr = 1'b0;
  logic                 pinLow = 1'b0, bgMode = 1'b0, software_interrupt_instr = 1'b0, coreHold, loadAx;
  logic [7:0]           irqFlag, fillByte;
  logic [7:0]           irqEvent = 8'h00, irqClear = 8'h00, irqEnable = 8'h00;
  rwic_pkg::rwic_opt_t  optWdata = '0, optState;
  rwic_pkg::rwic_regs_t coreRegs = '0, loadRegs;
  logic [15:0]          coreSp = 16'h00f0, loadSp, memAddr;
  logic                 resetPinIn, resetPinOe, sysReset, optLocked, regLoad, memWr, memRd;
  logic [7:0]           resetCause, memRdata, memWdata;
  logic [39:0]          expQ[$];
  int                   n_mismatch = 0, checks_done = 0, w;

  // pin pulled up unless the block or an outside switch drives it low
  assign resetPinIn = (resetPinOe || pinLow) ? 1'b0 : 1'b1;
  always #5 core_clk = ~core_clk;

  rwic_top #(.WD_SHORT_CYC(64), .WD_LONG_CYC(256)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .lvdReset(1'b0), .illegalOpReset(1'b0),
    .illegalAddrReset(1'b0), .debugReset(1'b0), .resetPinIn(resetPinIn),
    .resetPinOut(), .resetPinOe(resetPinOe), .sysReset(sysReset),
    .resetCause(resetCause), .causeWrite(causeWrite), .optWrite(optWrite),
    .optWdata(optWdata), .optState(optState), .optLocked(optLocked),
    .backgroundActive(bgMode), .irqEvent(irqEvent), .irqClear(irqClear),
    .irqEnable(irqEnable), .irqFlag(irqFlag), .instrBoundary(boundary), .swiExec(software_interrupt_instr),
    .rtiExec(return_from_interrupt_instr), .coreRegs(coreRegs), .coreSp(coreSp), .coreHold(coreHold),
    .regLoad(regLoad), .loadRegs(loadRegs), .loadSp(loadSp), .loadAx(loadAx),
    .memAddr(memAddr), .memWdata(memWdata), .memWr(memWr), .memRd(memRd),
    .memRdata(memRdata), .fillByte(fillByte), .fillValid());
  rwic_mem_model mm (.clk(core_clk), .addr(memAddr), .wdata(memWdata), .wr(memWr),
    .rd(memRd), .rdata(memRdata));

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] + 8'h11;
  endfunction
  task automatic wait_hi(ref logic s, input int lim);
    w = 0;
    @(posedge core_clk);
    while (s !== 1'b1 && w < lim) begin
      @(posedge core_clk);
      w++;
    end
    if (w >= lim) check(40'h0, 40'h1);
    @(negedge core_clk);
  endtask
  task automatic stop_test();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // each load pulse is compared with the oldest expected note
  always @(negedge core_clk) begin
    if (regLoad === 1'b1) begin
      if (expQ.size() == 0) check(40'h0, 40'h1);
      else check({loadRegs.pc, loadSp, resetCause}, expQ.pop_front());
    end
  end

  initial begin
    #30us;
    check(40'h0, 40'h1);
    stop_test();
  end

  initial begin
    logic [39:0] fr;
    logic [15:0] va;
    int src;
    void'($urandom(62));
    repeat (4) @(negedge core_clk);
    rst_b = 1'b1;
    // power-on entry: vector fetch, fixed stack, mask set
    expQ.push_back({mb(16'hfffe), mb(16'hffff), rwic_pkg::SP_INIT, rwic_pkg::CAUSE_POR});
    wait_hi(regLoad, 300);
    check({39'h0, loadRegs.condition_code_reg[3]}, 40'h1);
    $display("test reset done");
    // two enabled sources pending, highest index is taken; frame checked
    causeWrite = 1'b1;
    src = $urandom_range(6, 0);
    irqEvent = 8'h80 | (8'h01 << src);
    irqEnable = irqEvent;
    coreRegs = {16'($urandom), 8'($urandom), 8'($urandom), 8'h00};
    fr = {coreRegs.pc[7:0], coreRegs.pc[15:8], coreRegs.x, coreRegs.a, coreRegs.condition_code_reg};
    va = rwic_pkg::IRQ_VEC_LOW + 16'h000e;
    expQ.push_back({mb(va), mb(va + 16'h1), coreSp - 16'h5, rwic_pkg::CAUSE_POR});
    @(negedge core_clk);
    causeWrite = 1'b0;
    irqEvent = 8'h00;
    boundary = 1'b1;
    @(negedge core_clk);
    boundary = 1'b0;
    wait_hi(regLoad, 100);
    check({39'h0, loadRegs.condition_code_reg[3]}, 40'h1);
    for (int k = 0; k < 5; k++)
      check({32'h0, mm.mem[coreSp - 16'(k)]}, {32'h0, fr[39-8*k -: 8]});
    check({32'h0, mm.mem[coreSp - 16'h5]}, {32'h0, mb(coreSp - 16'h5)});
    irqClear = 8'hff;
    coreSp = coreSp - 16'h5;
    return_from_interrupt_instr = 1'b1;
    expQ.push_back({fr[31:24], fr[39:32], coreSp + 16'h5, rwic_pkg::CAUSE_POR});
    @(negedge core_clk);
    irqClear = 8'h00;
    return_from_interrupt_instr = 1'b0;
    wait_hi(regLoad, 100);
    check({31'h0, loadAx, loadRegs.a}, {31'h0, 1'b1, fr[15:8]});
    $display("test interrupt done");
    // lock short timeout; the later disabling write must be ignored
    optWdata = 2'b10;
    optWrite = 1'b1;
    causeWrite = 1'b1;
    @(negedge core_clk);
    optWdata = 2'b00;
    causeWrite = 1'b0;
    @(negedge core_clk);
    optWrite = 1'b0;
    check({37'h0, optLocked, optState}, 40'h6);
    expQ.push_back({mb(16'hfffe), mb(16'hffff), rwic_pkg::SP_INIT, rwic_pkg::CAUSE_WDOG});
    wait_hi(sysReset, 200);
    check({39'h0, w >= 58 && w <= 70}, 40'h1);
    wait_hi(regLoad, 300);
    check({38'h0, optState}, 40'h3);
    $display("test watchdog done");
    // pin held low from outside past its sample: reset again, cause is the pin
    pinLow = 1'b1;
    expQ.push_back({mb(16'hfffe), mb(16'hffff), rwic_pkg::SP_INIT, rwic_pkg::CAUSE_PIN});
    repeat (110) @(negedge core_clk);
    pinLow = 1'b0;
    wait_hi(regLoad, 300);
    check({32'h0, resetCause}, {32'h0, rwic_pkg::CAUSE_PIN});
    $display("test pin done");
    // debug halt stops the watchdog; a masked request only sets its flag
    bgMode = 1'b1;
    irqEvent = 8'h01;
    irqEnable = 8'h01;
    coreRegs.condition_code_reg = rwic_pkg::CCR_I_MASK;
    @(negedge core_clk);
    irqEvent = 8'h00;
    boundary = 1'b1;
    @(negedge core_clk);
    boundary = 1'b0;
    check({32'h0, irqFlag}, 40'h1);
    repeat (300) @(negedge core_clk);
    check({38'h0, sysReset, coreHold}, 40'h0);
    $display("test debug halt done");
    // software interrupt ignores the mask; watchdog locked off meanwhile
    bgMode = 1'b0;
    optWdata = 2'b00;
    optWrite = 1'b1;
    software_interrupt_instr = 1'b1;
    expQ.push_back({mb(16'hfffc), mb(16'hfffd), coreSp - 16'h5, rwic_pkg::CAUSE_PIN});
    @(negedge core_clk);
    optWrite = 1'b0;
    software_interrupt_instr = 1'b0;
    wait_hi(regLoad, 100);
    check({32'h0, fillByte}, {32'h0, mb(16'h0d10)});
    check({37'h0, optLocked, optState}, 40'h4);
    $display("test software interrupt done");
    stop_test();
  end
endmodule
`default_nettype wire
